// file: gsp_column_driver.sv
// gray-shade pulse-width column driver, 32 channels
//
// Behaviour
// - capture one 8-bit shade value on each shift clock edge while selected
// - values fill channel latches in arrival order, channel 1 through 32
// - bus bit 8 is the most significant bit of the shade value
// - master counter advances on each rising and falling count clock edge
// - counter falls from all ones to 00000001, then counts upward
// - during the down count an output goes high when counter equals its value
// - a high output returns low at the next match during the up count; 00000001 and 11111111 have none and stay high to cycle end
// - a channel holding 00000000 never pulses and stays low
// - cycle completes when counter reaches 11111111 counting upward
// - blank sets the counter to all ones and drives every output low
// - shade data is accepted only while chip select input is asserted
// - a chain select output enables the next device in a chain
// - a load-count pulse starts a counting cycle
`include "gsp_defs.svh"
`timescale 1ns/10ps

module gsp_column_driver #(
	parameter int SHADE_W = `GSP_SHADE_W,
	parameter int CHANNELS = `GSP_CHANNELS
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic shift_clk_in,
	input wire logic [SHADE_W-1:0] shade_value_bus_in,
	input wire logic chip_select_in,
	input wire logic count_clk_in,
	input wire logic load_count_in,
	input wire logic blank_in,
	output logic chain_select_out,
	output logic [CHANNELS-1:0] channel_drive_output_out
);

	// ****************************************
	// shift clock domain
	// ****************************************
	logic lrst_meta_q;
	logic lrst_q;
	logic [SHADE_W-1:0] rise_byte_q;
	logic [SHADE_W-1:0] fall_byte_q;
	logic rise_tog_q;
	logic fall_tog_q;

	always_ff @(posedge shift_clk_in) begin
		lrst_meta_q <= sys_rst_in;
		lrst_q <= lrst_meta_q;
	end

	always_ff @(posedge shift_clk_in) begin
		if (lrst_q) begin
			rise_tog_q <= 1'b0;
			rise_byte_q <= '0;
		end else if (chip_select_in) begin
			rise_byte_q <= shade_value_bus_in;
			rise_tog_q <= ~rise_tog_q;
		end
	end

	always_ff @(negedge shift_clk_in) begin
		if (lrst_q) begin
			fall_tog_q <= 1'b0;
			fall_byte_q <= '0;
		end else if (chip_select_in) begin
			fall_byte_q <= shade_value_bus_in;
			fall_tog_q <= ~fall_tog_q;
		end
	end

	// ****************************************
	// input sampling
	// ****************************************
	logic cc_lvl;
	logic ld_lvl;
	logic blk_lvl;
	logic cs_lvl;
	logic rtog_lvl;
	logic ftog_lvl;

	gsp_pin_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.clk_in(ref_clk_in),
		.rst_in(sys_rst_in),
		.async_in({count_clk_in, load_count_in, blank_in, chip_select_in}),
		.level_out({cc_lvl, ld_lvl, blk_lvl, cs_lvl})
	);

	gsp_pin_sync #(
		.WIDTH(2)
	) u_tog_sync (
		.clk_in(ref_clk_in),
		.rst_in(sys_rst_in),
		.async_in({rise_tog_q, fall_tog_q}),
		.level_out({rtog_lvl, ftog_lvl})
	);

	logic cc_prev_q;
	logic ld_prev_q;
	logic cs_prev_q;
	logic rtog_prev_q;
	logic ftog_prev_q;
	logic cc_edge;
	logic ld_rise;
	logic cs_fall;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cc_prev_q <= 1'b0;
			ld_prev_q <= 1'b0;
			cs_prev_q <= 1'b0;
			rtog_prev_q <= 1'b0;
			ftog_prev_q <= 1'b0;
		end else begin
			cc_prev_q <= cc_lvl;
			ld_prev_q <= ld_lvl;
			cs_prev_q <= cs_lvl;
			rtog_prev_q <= rtog_lvl;
			ftog_prev_q <= ftog_lvl;
		end
	end

	assign cc_edge = cc_lvl ^ cc_prev_q;
	assign ld_rise = ld_lvl && !ld_prev_q;
	assign cs_fall = !cs_lvl && cs_prev_q;

	// ****************************************
	// edge ordering into the buffer
	// ****************************************
	logic pend_r_q;
	logic pend_f_q;
	logic want_fall_q;
	logic sel_rise;
	logic push_valid;
	logic push_ready;
	logic push_fire;
	logic [SHADE_W-1:0] push_data;

	assign sel_rise = pend_r_q && (!pend_f_q || !want_fall_q);
	assign push_valid = pend_r_q || pend_f_q;
	assign push_data = sel_rise ? rise_byte_q : fall_byte_q;
	assign push_fire = push_valid && push_ready;

	// arrival wins over take
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			pend_r_q <= 1'b0;
			pend_f_q <= 1'b0;
			want_fall_q <= 1'b0;
		end else begin
			if (rtog_lvl != rtog_prev_q) begin
				pend_r_q <= 1'b1;
			end else if (push_fire && sel_rise) begin
				pend_r_q <= 1'b0;
			end
			if (ftog_lvl != ftog_prev_q) begin
				pend_f_q <= 1'b1;
			end else if (push_fire && !sel_rise) begin
				pend_f_q <= 1'b0;
			end
			if (push_fire) begin
				want_fall_q <= sel_rise;
			end
		end
	end

	logic pop_valid;
	logic pop_ready;
	logic [SHADE_W-1:0] pop_data;
	logic wr_fire;

	gsp_pair_buf #(
		.WIDTH(SHADE_W),
		.DEPTH(2)
	) u_pair_buf (
		.clk_in(ref_clk_in),
		.rst_in(sys_rst_in),
		.in_valid_in(push_valid),
		.in_ready_out(push_ready),
		.in_data_in(push_data),
		.out_valid_out(pop_valid),
		.out_ready_in(pop_ready),
		.out_data_out(pop_data)
	);

	// latch writes pause in a count edge cycle
	assign pop_ready = !cc_edge;
	assign wr_fire = pop_valid && pop_ready;

	// ****************************************
	// channel latches and chaining
	// ****************************************
	logic [SHADE_W-1:0] latch_q [CHANNELS];
	logic [`GSP_IDX_W-1:0] idx_q;
	logic full_q;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < CHANNELS; i++) begin
				latch_q[i] <= '0;
			end
		end else if (wr_fire && !full_q) begin
			latch_q[idx_q] <= pop_data;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			idx_q <= '0;
			full_q <= 1'b0;
			chain_select_out <= 1'b0;
		end else if (cs_fall) begin
			idx_q <= '0;
			full_q <= 1'b0;
			chain_select_out <= 1'b0;
		end else if (wr_fire && !full_q) begin
			idx_q <= idx_q + 1'b1;
			if (idx_q == `GSP_IDX_LAST) begin
				full_q <= 1'b1;
				chain_select_out <= 1'b1;
			end
		end
	end

	// ****************************************
	// master counter
	// ****************************************
	gsp_pkg::gsp_cnt_state_type state_q;
	logic [SHADE_W-1:0] cnt_q;
	logic cycle_done;

	assign cycle_done = (state_q == gsp_pkg::GSP_CNT_UP) && cc_edge
		&& (cnt_q == `GSP_CNT_LAST_UP);

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || blk_lvl) begin
			state_q <= gsp_pkg::GSP_CNT_IDLE;
			cnt_q <= `GSP_CNT_TOP;
		end else begin
			unique case (state_q)
				gsp_pkg::GSP_CNT_IDLE: begin
					cnt_q <= `GSP_CNT_TOP;
					if (ld_rise) begin
						state_q <= gsp_pkg::GSP_CNT_DOWN;
					end
				end
				gsp_pkg::GSP_CNT_DOWN: begin
					if (cc_edge) begin
						if (cnt_q == `GSP_CNT_TURN) begin
							cnt_q <= `GSP_CNT_AFTER_TURN;
							state_q <= gsp_pkg::GSP_CNT_UP;
						end else begin
							cnt_q <= cnt_q - 1'b1;
						end
					end
				end
				gsp_pkg::GSP_CNT_UP: begin
					if (cc_edge) begin
						cnt_q <= cnt_q + 1'b1;
						if (cycle_done) begin
							state_q <= gsp_pkg::GSP_CNT_IDLE;
						end
					end
				end
				default: begin
					state_q <= gsp_pkg::GSP_CNT_IDLE;
					cnt_q <= `GSP_CNT_TOP;
				end
			endcase
		end
	end

	// ****************************************
	// channel comparators
	// ****************************************
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
		always_ff @(posedge ref_clk_in) begin
			if (sys_rst_in || blk_lvl) begin
				channel_drive_output_out[ch] <= 1'b0;
			end else if (cycle_done) begin
				channel_drive_output_out[ch] <= 1'b0;
			end else if (state_q == gsp_pkg::GSP_CNT_DOWN && cnt_q == latch_q[ch]) begin
				channel_drive_output_out[ch] <= 1'b1;
			end else if (state_q == gsp_pkg::GSP_CNT_UP && cnt_q == latch_q[ch]) begin
				channel_drive_output_out[ch] <= 1'b0;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb_sys @(posedge ref_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	sequence s_turn_edge;
		state_q == gsp_pkg::GSP_CNT_DOWN && cnt_q == `GSP_CNT_TURN && cc_edge && !blk_lvl;
	endsequence

	sequence s_last_up_edge;
		state_q == gsp_pkg::GSP_CNT_UP && cnt_q == `GSP_CNT_LAST_UP && cc_edge && !blk_lvl;
	endsequence

	AST_BLANK_CLEARS: assert property (blk_lvl |=>
		channel_drive_output_out == '0 && cnt_q == `GSP_CNT_TOP)
		else $error("blank did not clear counter and outputs");

	AST_LOAD_STARTS: assert property (ld_rise && !blk_lvl
		&& state_q == gsp_pkg::GSP_CNT_IDLE
		|=> state_q == gsp_pkg::GSP_CNT_DOWN && cnt_q == `GSP_CNT_TOP)
		else $error("load pulse did not start the down count");

	AST_DOWN_STEP: assert property (state_q == gsp_pkg::GSP_CNT_DOWN
		&& cc_edge && cnt_q != `GSP_CNT_TURN && !blk_lvl
		|=> cnt_q == $past(cnt_q) - 8'h01)
		else $error("down count did not step by one");

	AST_TURNAROUND: assert property (s_turn_edge
		|=> state_q == gsp_pkg::GSP_CNT_UP && cnt_q == `GSP_CNT_AFTER_TURN)
		else $error("counter did not reverse at one");

	AST_CYCLE_DONE: assert property (s_last_up_edge
		|=> state_q == gsp_pkg::GSP_CNT_IDLE && cnt_q == `GSP_CNT_TOP
		&& channel_drive_output_out == '0)
		else $error("cycle did not end at all ones");

	AST_IDLE_HOLD: assert property (state_q == gsp_pkg::GSP_CNT_IDLE && !ld_rise
		|=> state_q == gsp_pkg::GSP_CNT_IDLE && cnt_q == `GSP_CNT_TOP)
		else $error("idle counter moved");

	AST_ZERO_NO_PULSE: assert property (latch_q[0] == `GSP_SHADE_OFF
		&& !channel_drive_output_out[0] ##1 latch_q[0] == `GSP_SHADE_OFF
		|-> !channel_drive_output_out[0])
		else $error("zero shade produced a pulse");

	AST_MATCH_SETS: assert property (state_q == gsp_pkg::GSP_CNT_DOWN
		&& cnt_q == latch_q[3] && !blk_lvl |=> channel_drive_output_out[3])
		else $error("down match did not raise output");

	AST_MATCH_CLEARS: assert property (state_q == gsp_pkg::GSP_CNT_UP
		&& cnt_q == latch_q[3] |=> !channel_drive_output_out[3])
		else $error("up match did not drop output");

	AST_CHAIN_AFTER_LAST: assert property (wr_fire && !full_q
		&& idx_q == `GSP_IDX_LAST && !cs_fall
		|=> (chain_select_out && full_q) ##1 (chain_select_out || $past(cs_fall)))
		else $error("chain select not raised after last channel");

	AST_IGNORE_WHEN_FULL: assert property (full_q && wr_fire
		|=> latch_q[0] == $past(latch_q[0]) && idx_q == $past(idx_q))
		else $error("data written after all channels filled");

endmodule : gsp_column_driver

// file: gsp_ctrl_model.sv
// display controller model driving shade frames, load, count and blank
`timescale 1ns/10ps

module gsp_ctrl_model (
	input wire logic ref_clk_in,
	output logic shift_clk_out,
	output logic [7:0] shade_out,
	output logic chip_select_out,
	output logic count_clk_out,
	output logic load_count_out,
	output logic blank_out
);
	// ****************************************
	// shift link, clock stands still outside frames except in shift_idle
	// ****************************************
	initial begin
		shift_clk_out = 1'b0;
		shade_out = 8'h5A;
		chip_select_out = 1'b0;
		count_clk_out = 1'b0;
		load_count_out = 1'b0;
		blank_out = 1'b0;
	end

	task automatic shift_idle(input int n);
		repeat (n) #32 shift_clk_out = ~shift_clk_out;
	endtask : shift_idle

	task automatic send_frame(input logic [7:0] vals [$], input logic sel);
		@(posedge ref_clk_in) chip_select_out <= sel;
		foreach (vals[i]) begin
			#16 shade_out = vals[i];
			#16 shift_clk_out = ~shift_clk_out;
		end
		#16 shade_out = ~shade_out;
		repeat (20) @(posedge ref_clk_in);
	endtask : send_frame

	task automatic deselect();
		@(posedge ref_clk_in) chip_select_out <= 1'b0;
		repeat (20) @(posedge ref_clk_in);
	endtask : deselect

	// ****************************************
	// count control
	// ****************************************
	task automatic load_pulse();
		@(posedge ref_clk_in) load_count_out <= 1'b1;
		repeat (8) @(posedge ref_clk_in);
		load_count_out <= 1'b0;
		repeat (10) @(posedge ref_clk_in);
	endtask : load_pulse

	task automatic count_edge(input int turn_pause);
		repeat (turn_pause) @(posedge ref_clk_in);
		@(posedge ref_clk_in) count_clk_out <= ~count_clk_out;
		repeat (7) @(posedge ref_clk_in);
	endtask : count_edge

	task automatic set_blank(input logic v);
		@(posedge ref_clk_in) blank_out <= v;
		repeat (70) @(posedge ref_clk_in);
	endtask : set_blank
endmodule : gsp_ctrl_model

// file: gsp_defs.svh
// constants for the gray-shade pulse-width column driver
`ifndef GSP_DEFS_SVH
`define GSP_DEFS_SVH

// ****************************************
// data path
// ****************************************
`define GSP_SHADE_W 8
`define GSP_CHANNELS 32
`define GSP_IDX_W 5
`define GSP_IDX_LAST 5'h1F

// ****************************************
// master counter values
// ****************************************
`define GSP_CNT_TOP 8'hFF
`define GSP_CNT_TURN 8'h01
`define GSP_CNT_AFTER_TURN 8'h02
`define GSP_CNT_LAST_UP 8'hFE
`define GSP_SHADE_OFF 8'h00

// ****************************************
// timing, controller side
// ****************************************
`define GSP_CLK_PERIOD_NS 10
`define GSP_LOAD_PULSE_MIN_NS 75
`define GSP_LOAD_TO_COUNT_MIN_NS 100
`define GSP_TURN_PAUSE_MIN_NS 500
`define GSP_LOAD_PULSE_CYC ((`GSP_LOAD_PULSE_MIN_NS + `GSP_CLK_PERIOD_NS - 1) / `GSP_CLK_PERIOD_NS)
`define GSP_LOAD_TO_COUNT_CYC ((`GSP_LOAD_TO_COUNT_MIN_NS + `GSP_CLK_PERIOD_NS - 1) / `GSP_CLK_PERIOD_NS)
`define GSP_TURN_PAUSE_CYC ((`GSP_TURN_PAUSE_MIN_NS + `GSP_CLK_PERIOD_NS - 1) / `GSP_CLK_PERIOD_NS)

`endif

// file: gsp_pair_buf.sv
// two-entry valid/ready buffer
`timescale 1ns/10ps

module gsp_pair_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [PW:0] fill_q;
	logic push;
	logic pop;

	assign in_ready_out = (fill_q != (PW+1)'(DEPTH));
	assign out_valid_out = (fill_q != '0);
	assign out_data_out = mem_q[rd_q];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_q <= '0;
			rd_q <= '0;
			fill_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			if (push && !pop) begin
				fill_q <= fill_q + 1'b1;
			end else if (pop && !push) begin
				fill_q <= fill_q - 1'b1;
			end
		end
	end

endmodule : gsp_pair_buf

// file: gsp_pin_sync.sv
// three-stage input sampler with agreement filter
`timescale 1ns/10ps

module gsp_pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level_out
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	always_ff @(posedge clk_in) begin
		s1_q <= async_in;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	// a bit moves only once stages two and three agree
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			level_out <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					level_out[i] <= s3_q[i];
				end
			end
		end
	end

endmodule : gsp_pin_sync

// file: gsp_pkg.sv
// types for the gray-shade pulse-width column driver
package gsp_pkg;

	typedef enum logic [1:0] {
		GSP_CNT_IDLE = 2'h0,
		GSP_CNT_DOWN = 2'h1,
		GSP_CNT_UP = 2'h2
	} gsp_cnt_state_type;

endpackage : gsp_pkg

// file: tb_top.sv
// self-checking testbench for the column driver
`timescale 1ns/10ps

module tb_top;
	logic ref_clk_in;
	logic sys_rst_in;
	logic shift_clk;
	logic [7:0] shade;
	logic cs;
	logic cnt_clk;
	logic load;
	logic blank;
	logic chain_sel;
	logic [31:0] drive;
	logic [31:0] exp_drive;
	logic [7:0] lat_m [32];
	logic [7:0] frame [$];
	int err_total;
	int total_checks;

	// ****************************************
	// clock, design and controller
	// ****************************************
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end

	gsp_column_driver u_dut (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.shift_clk_in(shift_clk),
		.shade_value_bus_in(shade),
		.chip_select_in(cs),
		.count_clk_in(cnt_clk),
		.load_count_in(load),
		.blank_in(blank),
		.chain_select_out(chain_sel),
		.channel_drive_output_out(drive)
	);

	gsp_ctrl_model u_ctrl (
		.ref_clk_in(ref_clk_in),
		.shift_clk_out(shift_clk),
		.shade_out(shade),
		.chip_select_out(cs),
		.count_clk_out(cnt_clk),
		.load_count_out(load),
		.blank_out(blank)
	);

	// ****************************************
	// checking and reference model
	// ****************************************
	task automatic conclude();
		if (err_total == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		#1;
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic run_cycle(input int edges);
		int c;
		int up;
		u_ctrl.load_pulse();
		c = 255;
		up = 0;
		exp_drive = '0;
		foreach (lat_m[i]) if (lat_m[i] == 8'hFF) exp_drive[i] = 1'b1;
		check("drive at load", exp_drive, drive);
		for (int e = 0; e < edges; e++) begin
			u_ctrl.count_edge((e == 254) ? 50 : 0);
			if (up == 0 && c == 1)
				up = 1;
			c = (up == 1) ? c + 1 : c - 1;
			foreach (lat_m[i]) begin
				if (up == 0 && lat_m[i] == c) exp_drive[i] = 1'b1;
				if (up == 1 && lat_m[i] == c) exp_drive[i] = 1'b0;
			end
			if (c == 255)
				exp_drive = '0;
			check("drive per count", exp_drive, drive);
		end
	endtask : run_cycle

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h20F7DC68));
		err_total = 0;
		total_checks = 0;
		sys_rst_in = 1'b1;
		u_ctrl.shift_idle(8);
		repeat (8) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		// two rising link edges release the link-side reset before data
		u_ctrl.shift_idle(4);
		repeat (5) @(posedge ref_clk_in);
		check("chain after reset", 32'h0, {31'h0, chain_sel});
		for (int i = 0; i < 34; i++) frame.push_back(8'($urandom));
		frame[0] = 8'h00;
		frame[1] = 8'h01;
		frame[2] = 8'hFF;
		frame[3] = 8'h80;
		for (int i = 0; i < 32; i++) lat_m[i] = frame[i];
		u_ctrl.send_frame(frame[0:30], 1'b1);
		check("chain before last", 32'h0, {31'h0, chain_sel});
		u_ctrl.send_frame(frame[31:33], 1'b1);
		check("chain after last", 32'h1, {31'h0, chain_sel});
		u_ctrl.deselect();
		check("chain after deselect", 32'h0, {31'h0, chain_sel});
		run_cycle(508);
		repeat (3) u_ctrl.count_edge(0);
		check("idle drive", 32'h0, drive);
		for (int i = 0; i < 32; i++) frame[i] = ~lat_m[i];
		u_ctrl.send_frame(frame[0:31], 1'b0);
		run_cycle(100);
		u_ctrl.set_blank(1'b1);
		check("drive in blank", 32'h0, drive);
		u_ctrl.set_blank(1'b0);
		run_cycle(508);
		conclude();
	end

	initial begin
		repeat (100000) @(posedge ref_clk_in);
		err_total++;
		conclude();
	end
endmodule : tb_top
